// ---- block_xfer_slave.sv ----
// Backplane slave: block transfers, read-modify-write, local lockout
`timescale 1ns/100ps
`default_nettype none
module block_xfer_slave
  import block_xfer_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BASE_ADDR = 32'h0000_0000, // Decoded window
  parameter logic [ADDR_W-1:0] SEL_MASK  = 32'hFF00_0000, // Upper bits decoded
  parameter logic [5:0]        AM_BLT    = 6'h01,         // Block code
  parameter logic [5:0]        AM_A40BLT = 6'h02,         // 40-bit block code
  parameter logic [5:0]        AM_MBLT   = 6'h03,         // Multiplexed code
  parameter logic              UAT_CAP   = 1'b0,          // Unaligned support
  parameter int                DEPTH     = FIFO_DEPTH     // Write buffer depth
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  input  wire logic              as_b_i,
  input  wire logic [1:0]        ds_b_i,
  input  wire logic              write_b_i,
  input  wire logic              iack_b_i,
  input  wire logic [5:0]        am_i,
  input  wire logic [31:1]       addr_i,
  input  wire logic              lword_b_i,
  input  wire logic [31:0]       data_i,
  output logic      [31:1]       addr_o,
  output logic                   lword_o,
  output logic                   addr_oe_o,
  output logic      [31:0]       data_o,
  output logic                   data_oe_o,
  output logic                   dtack_oe_o,
  output logic                   berr_oe_o,
  output logic                   rd_req_o,
  output logic      [ADDR_W-1:0] rd_addr_o,
  input  wire logic              rd_valid_i,
  input  wire logic [63:0]       rd_data_i,
  output logic                   wr_valid_o,
  input  wire logic              wr_ready_i,
  output wr_word_s               wr_word_o,
  input  wire logic              local_req_i,
  output logic                   local_grant_o,
  input  wire logic [ADDR_W-1:0] watch_addr_i,
  output logic                   lm_hit_o
);
  // Bytes moved by one beat
  function automatic logic [3:0] beat_bytes(input logic [1:0] ds, input logic lw,
                                            input cyc_e kind);
    if (kind == CYC_MBLT) return NB_8;
    else if (ds != 2'h0) return NB_1;
    else if (!lw) return NB_4;
    else return NB_2;
  endfunction

  // Next counter value, counting only the low field
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [3:0] nb, input logic mux);
    logic [MBLT_WIN_W-1:0] lo_m;
    logic [BLT_WIN_W-1:0]  lo_s;
    lo_m = a[MBLT_WIN_W-1:0] + MBLT_WIN_W'(nb);
    lo_s = a[BLT_WIN_W-1:0] + BLT_WIN_W'(nb);
    if (mux) return {a[ADDR_W-1:MBLT_WIN_W], lo_m};
    else return {a[ADDR_W-1:BLT_WIN_W], lo_s};
  endfunction

  // Modifier decode
  function automatic cyc_e am_kind(input logic [5:0] am);
    if (am == AM_BLT) return CYC_BLT;
    else if (am == AM_A40BLT) return CYC_A40BLT;
    else if (am == AM_MBLT) return CYC_MBLT;
    else return CYC_SINGLE;
  endfunction

  state_e            state_reg;     // Sequencer state
  state_e            state_next;    // Its next value
  logic              as_prev_reg;   // Address strobe one cycle ago
  logic [ADDR_W-1:0] addr_cnt_reg;  // Block address counter
  cyc_e              kind_reg;      // Latched cycle kind
  logic              sel_reg;       // This slave addressed
  logic [3:0]        nbytes_reg;    // Width of current beat
  logic              wr_reg;        // Current beat is a write

  wire               as_fall;       // Strobe falling edge
  wire               ds_any;        // Any data strobe low
  wire               ds_idle;       // Both data strobes high
  wire               block;         // Latched cycle is a block
  wire               unaligned;     // Triple or middle double beat
  wire               bad_beat;      // Beat we must refuse
  wire               beat_end;      // Acked beat closes
  wire               fifo_in_valid; // Push request
  wire               fifo_in_ready; // Buffer has room
  wire [ADDR_W-1:0]  beat_addr;     // Address of this beat
  wire [3:0]         nb_now;        // Width seen on the strobes
  wire [63:0]        beat_data;     // Data of a write beat
  wr_word_s          push_word;     // Word pushed into buffer

  assign as_fall   = as_prev_reg && !as_b_i;
  assign ds_any    = (ds_b_i != 2'h3);
  assign ds_idle   = (ds_b_i == 2'h3);
  assign block     = (kind_reg != CYC_SINGLE);
  // Aligned four bytes use both strobes with address bit one low
  assign unaligned = !lword_b_i && !((ds_b_i == 2'h0) && !addr_cnt_reg[1]);
  assign bad_beat  = unaligned && (block || !UAT_CAP);
  assign beat_end  = (state_reg == S_ACK) && ds_idle;
  assign nb_now    = beat_bytes(ds_b_i, lword_b_i, kind_reg);
  assign beat_addr = {addr_cnt_reg[ADDR_W-1:1],
                      (kind_reg != CYC_MBLT) && (ds_b_i == DS_ODD)};
  // Multiplexed beats carry the upper word on address lines
  assign beat_data = (kind_reg == CYC_MBLT) ? {addr_i, lword_b_i, data_i}
                                            : {32'h0000_0000, data_i};
  assign push_word     = '{addr: beat_addr, data: beat_data, nbytes: nbytes_reg};
  assign fifo_in_valid = (state_reg == S_WR);

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        // Interrupt acknowledge cycles are ignored
        if (as_fall && iack_b_i) state_next = S_ADDR;
      end
      S_ADDR: begin
        if (as_b_i) begin
          state_next = S_IDLE;
        end else if (ds_any && sel_reg) begin
          if (bad_beat) state_next = S_ERR;
          else if (!write_b_i) state_next = S_WR;
          else state_next = S_RD;
        end
      end
      S_WR: begin
        // Full buffer stalls the acknowledge
        if (fifo_in_ready) state_next = S_ACK;
      end
      S_RD: begin
        if (rd_valid_i) state_next = S_ACK;
      end
      S_ACK: begin
        if (ds_idle) state_next = S_ADDR;
      end
      S_ERR: begin
        if (ds_idle) state_next = S_ADDR;
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Sequencer state and strobe history
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg   <= S_IDLE;
      as_prev_reg <= 1'b1;
    end else if (ce_i) begin
      state_reg   <= state_next;
      as_prev_reg <= as_b_i;
    end
  end

  // Addressing capture, decoded once per block
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kind_reg <= CYC_SINGLE;
      sel_reg  <= 1'b0;
    end else if (ce_i && state_reg == S_IDLE && as_fall) begin
      kind_reg <= am_kind(am_i);
      sel_reg  <= (({addr_i, 1'b0} & SEL_MASK) == BASE_ADDR) && iack_b_i;
    end
  end

  // Block address counter
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_cnt_reg <= ADDR_ZERO;
    end else if (ce_i) begin
      if (state_reg == S_IDLE && as_fall) addr_cnt_reg <= {addr_i, 1'b0};
      else if (state_reg == S_IDLE && as_b_i) addr_cnt_reg <= ADDR_ZERO;
      else if (beat_end && block)
        addr_cnt_reg <= next_addr(addr_cnt_reg, nbytes_reg, kind_reg == CYC_MBLT);
    end
  end

  // Beat width and direction at beat start
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nbytes_reg <= NB_1;
      wr_reg     <= 1'b0;
    end else if (ce_i && state_reg == S_ADDR && ds_any) begin
      nbytes_reg <= nb_now;
      wr_reg     <= !write_b_i;
    end
  end

  // Bus responses
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dtack_oe_o <= 1'b0;
      berr_oe_o  <= 1'b0;
      data_oe_o  <= 1'b0;
      addr_oe_o  <= 1'b0;
    end else if (ce_i) begin
      dtack_oe_o <= (state_next == S_ACK);
      berr_oe_o  <= (state_next == S_ERR);
      data_oe_o  <= (state_next == S_ACK) && !wr_reg;
      addr_oe_o  <= (state_next == S_ACK) && !wr_reg && (kind_reg == CYC_MBLT);
    end
  end

  // Read request and returned data
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_req_o  <= 1'b0;
      rd_addr_o <= ADDR_ZERO;
      data_o    <= 32'h0000_0000;
      addr_o    <= 31'h0000_0000;
      lword_o   <= 1'b0;
    end else if (ce_i) begin
      rd_req_o <= (state_reg == S_ADDR) && (state_next == S_RD);
      if (state_reg == S_ADDR) rd_addr_o <= beat_addr;
      if (state_reg == S_RD && rd_valid_i) begin
        data_o  <= rd_data_i[31:0];
        addr_o  <= rd_data_i[63:33];
        lword_o <= rd_data_i[32];
      end
    end
  end

  // Local port lockout and location monitor
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      local_grant_o <= 1'b0;
      lm_hit_o      <= 1'b0;
    end else if (ce_i) begin
      local_grant_o <= local_req_i && !(!as_b_i && sel_reg && state_reg != S_IDLE);
      lm_hit_o      <= beat_end && (beat_addr[ADDR_W-1:3] == watch_addr_i[ADDR_W-1:3]);
    end
  end

  // Write buffer toward the user side
  block_xfer_fifo #(
    .WIDTH ($bits(wr_word_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_word),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (wr_word_o)
  );

  // Start address lands in the counter
  property p_load;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == S_IDLE && as_fall && ce_i) |=> addr_cnt_reg == {$past(addr_i), 1'b0};
  endproperty
  a_load: assert property (p_load) else $error("start address not loaded");

  // Standard block counts by beat width
  property p_step;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (beat_end && ce_i && (kind_reg == CYC_BLT || kind_reg == CYC_A40BLT))
      |=> (addr_cnt_reg[7:0] - $past(addr_cnt_reg[7:0])) == {4'h0, $past(nbytes_reg)};
  endproperty
  a_step: assert property (p_step) else $error("counter step wrong");

  // Upper address bits never move in a block
  property p_upper;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (beat_end && ce_i && block) |=> $stable(addr_cnt_reg[31:11]);
  endproperty
  a_upper: assert property (p_upper) else $error("upper address changed");

  // Counter cleared while strobe high
  property p_clear;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == S_IDLE && as_b_i && ce_i) |=> addr_cnt_reg == ADDR_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not dropped");

  // Refused beat gets error, never acknowledge
  property p_refuse;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == S_ADDR && !as_b_i && ds_any && sel_reg && bad_beat && ce_i)
      |=> berr_oe_o && !dtack_oe_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad beat acknowledged");

  // Local side locked out during bus access
  property p_lock;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (!as_b_i && (state_reg inside {S_WR, S_RD, S_ACK}) && ce_i) |=> !local_grant_o;
  endproperty
  a_lock: assert property (p_lock) else $error("local access during bus cycle");

  // Multiplexed beats move eight bytes
  property p_mux8;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (fifo_in_valid && kind_reg == CYC_MBLT) |-> push_word.nbytes == NB_8;
  endproperty
  a_mux8: assert property (p_mux8) else $error("multiplexed beat not eight bytes");

  // Single cycles keep one address for read then write
  property p_rmw;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (beat_end && !block && !as_b_i && ce_i) |=> $stable(addr_cnt_reg);
  endproperty
  a_rmw: assert property (p_rmw) else $error("address moved in single cycle");
endmodule
`default_nettype wire

// ---- block_xfer_pkg.sv ----
// Shared types and constants for the block transfer slave
package block_xfer_pkg;
  localparam int ADDR_W = 32;          // Byte address width
  localparam int BLT_WIN_W = 8;        // Counting field of a standard block
  localparam int MBLT_WIN_W = 11;      // Counting field of a multiplexed block
  localparam int MAX_XFERS = 256;      // Longest block a master may run
  localparam int FIFO_DEPTH = 8;       // Write buffer depth
  localparam logic [3:0] NB_1 = 4'h1;  // Bytes per beat
  localparam logic [3:0] NB_2 = 4'h2;
  localparam logic [3:0] NB_4 = 4'h4;
  localparam logic [3:0] NB_8 = 4'h8;
  localparam logic [1:0] DS_ODD = 2'h2; // Only the odd data strobe low
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;

  // Cycle kind from the address modifier
  typedef enum logic [1:0] {
    CYC_SINGLE = 2'h0,
    CYC_BLT    = 2'h1,
    CYC_A40BLT = 2'h2,
    CYC_MBLT   = 2'h3
  } cyc_e;

  // Slave sequencer, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_WR   = 6'h04,
    S_RD   = 6'h08,
    S_ACK  = 6'h10,
    S_ERR  = 6'h20
  } state_e;

  // One buffered bus write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [63:0]       data;
    logic [3:0]        nbytes;
  } wr_word_s;
endpackage

// ---- block_xfer_fifo.sv ----
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module block_xfer_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [PW:0]      wr_ptr_reg;   // Write pointer with wrap bit
  logic [PW:0]      rd_ptr_reg;   // Read pointer with wrap bit
  wire              push;
  wire              pop;
  wire              full;
  wire              empty;

  assign full  = (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]) && (wr_ptr_reg[PW] != rd_ptr_reg[PW]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign push  = ce_i && in_valid_i && !full;
  assign pop   = ce_i && out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr_reg[PW-1:0]];

  // Pointers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge mclk_i) begin
    if (push) mem[wr_ptr_reg[PW-1:0]] <= in_data_i;
  end
endmodule
`default_nettype wire

// ---- block_xfer_master.sv ----
// Bus master model that drives the slave's backplane side
`timescale 1ns/100ps
`default_nettype none
module block_xfer_master (
  input  wire logic        mclk_i,
  input  wire logic        dtack_i,
  input  wire logic        berr_i,
  input  wire logic [31:0] rdata_i,
  output logic             as_b_o = 1'b1,
  output logic [1:0]       ds_b_o = 2'h3,
  output logic             write_b_o = 1'b1,
  output logic             iack_b_o = 1'b1,
  output logic [5:0]       am_o = 6'h00,
  output logic [31:1]      addr_o = 31'h0,
  output logic             lword_b_o = 1'b1,
  output logic [31:0]      data_o = 32'h0
);
  // Address phase: lines settle a cycle before the strobe falls
  task automatic start(input logic [5:0] am, input logic [31:0] a,
                       input logic lw, input logic ik);
    @(negedge mclk_i);
    am_o = am;
    addr_o = a[31:1];
    lword_b_o = lw;
    iack_b_o = ik;
    @(negedge mclk_i);
    as_b_o = 1'b0;
  endtask

  // One beat; rsp 0 none, 1 acknowledged, 2 refused
  task automatic beat(input logic wr, input logic [1:0] ds, input logic [31:0] d,
                      input logic mux, input logic [31:0] hi,
                      output logic [1:0] rsp, output logic [31:0] rd);
    int i;
    rsp = 2'h0;
    rd = 32'h0;
    @(negedge mclk_i);
    write_b_o = ~wr;
    data_o = wr ? d : ~data_o;
    // Multiplexed beats carry the upper word on the address lines
    if (mux) begin
      addr_o = hi[31:1];
      lword_b_o = hi[0];
    end
    ds_b_o = ds;
    // Hold everything until an answer is sampled or 60 edges pass
    for (i = 0; i < 60 && rsp == 2'h0; i++) begin
      @(posedge mclk_i);
      if (dtack_i === 1'b1) begin
        rsp = 2'h1;
        rd = rdata_i;
      end else if (berr_i === 1'b1) begin
        rsp = 2'h2;
      end
    end
    @(negedge mclk_i);
    ds_b_o = 2'h3;
    data_o = ~data_o; // Released lines stop showing old data
    repeat (3) @(posedge mclk_i); // Answer drops at the first edge after release
  endtask

  // Strobe release ends the block; address lines no longer valid
  task automatic stop();
    @(negedge mclk_i);
    as_b_o = 1'b1;
    addr_o = ~addr_o;
    lword_b_o = ~lword_b_o;
    repeat (2) @(negedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the block transfer slave
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import block_xfer_pkg::*;
  localparam logic [5:0] AM_B = 6'h01;   // Block codes, arbitrary
  localparam logic [5:0] AM_A = 6'h02;
  localparam logic [5:0] AM_M = 6'h03;
  localparam logic [5:0] AM_S = 6'h09;   // Plain single cycle
  logic        mclk_i = 1'b0;            // Bench clock
  logic        rst_b = 1'b0;             // Reset, active low
  logic        ce = 1'b1;                // Clock enable
  logic        rd_valid = 1'b0;          // Local read answer
  logic [63:0] rd_data = 64'h0;
  logic        wr_ready = 1'b0;          // Local write pop
  logic        local_req = 1'b0;         // Local side request
  logic [31:0] watch = 32'h0;            // Monitored location
  logic [1:0]  rdy_mode = 2'h0;          // 0 stall, 1 random, 2 open
  wire         as_b, write_b, iack_b, m_lw, s_lw, bus_lw, addr_oe, data_oe;
  wire  [1:0]  ds_b;
  wire  [5:0]  am;
  wire  [31:1] m_addr, s_addr, bus_addr;
  wire  [31:0] m_data, s_data, bus_data, rd_addr;
  wire         dtack, berr, rd_req, wr_valid, local_grant, lm_hit;
  wr_word_s    wr_word;                  // Buffer head
  wr_word_s    ew;                       // Oldest expected word
  wr_word_s    wq[$];                    // Expected writes
  logic [31:0] raq[$];                   // Expected read addresses
  logic [1:0]  rsp;
  logic [31:0] rd, d;
  int          lm_cnt = 0;
  int          error_cnt = 0;
  int          n_tests = 0;

  // Wire level from whoever drives it
  assign bus_data = data_oe ? s_data : m_data;
  assign bus_addr = addr_oe ? s_addr : m_addr;
  assign bus_lw = addr_oe ? s_lw : m_lw;

  always #5 mclk_i = ~mclk_i;

  block_xfer_slave #(.AM_BLT(AM_B), .AM_A40BLT(AM_A), .AM_MBLT(AM_M)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b), .ce_i(ce), .as_b_i(as_b), .ds_b_i(ds_b),
    .write_b_i(write_b), .iack_b_i(iack_b), .am_i(am), .addr_i(bus_addr),
    .lword_b_i(bus_lw), .data_i(bus_data), .addr_o(s_addr), .lword_o(s_lw),
    .addr_oe_o(addr_oe), .data_o(s_data), .data_oe_o(data_oe), .dtack_oe_o(dtack),
    .berr_oe_o(berr), .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
    .wr_word_o(wr_word), .local_req_i(local_req), .local_grant_o(local_grant),
    .watch_addr_i(watch), .lm_hit_o(lm_hit));

  block_xfer_master m (
    .mclk_i(mclk_i), .dtack_i(dtack), .berr_i(berr), .rdata_i(s_data),
    .as_b_o(as_b), .ds_b_o(ds_b), .write_b_o(write_b), .iack_b_o(iack_b),
    .am_o(am), .addr_o(m_addr), .lword_b_o(m_lw), .data_o(m_data));

  // Compare and count
  task automatic chk(input logic [99:0] s, input logic [99:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Far side of the buffer: stalls, random pops or open
  always @(negedge mclk_i) begin
    wr_ready = (rdy_mode == 2'h2) || (rdy_mode == 2'h1 && $urandom_range(1, 0) == 1);
  end

  // Watch outputs and take the oldest note for each result
  always @(posedge mclk_i) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1 && ce === 1'b1) begin
      ew = (wq.size() > 0) ? wq.pop_front() : '1;
      chk({wr_word.addr, wr_word.nbytes}, {ew.addr, ew.nbytes});
      chk(wr_word.data[31:0], ew.data[31:0]);
      if (ew.nbytes == NB_8) chk(wr_word.data[63:32], ew.data[63:32]);
    end
    if (rd_req === 1'b1) chk(rd_addr, (raq.size() > 0) ? raq.pop_front() : '1);
    if (lm_hit === 1'b1) lm_cnt++;
  end

  // Local memory answers each read after a random delay
  always @(posedge mclk_i) begin
    if (rd_req === 1'b1) begin
      repeat ($urandom_range(2, 0)) @(negedge mclk_i);
      @(negedge mclk_i);
      rd_data = {$urandom, $urandom};
      rd_valid = 1'b1;
      @(negedge mclk_i);
      rd_valid = 1'b0;
    end
  end

  // Block of n beats, short and inside its boundary
  task automatic blk(input logic [5:0] amc, input logic [31:0] base,
                     input logic [3:0] nb, input logic wr, input int n);
    logic [1:0]  r;
    logic [1:0]  ds;
    logic [31:0] a, dd, hi, rr;
    int          k;
    m.start(amc, base, nb == NB_1 || nb == NB_2, 1'b1);
    for (k = 0; k < n; k++) begin
      a = base + k * nb;
      ds = (nb == NB_1) ? (a[0] ? 2'h2 : 2'h1) : 2'h0;
      dd = $urandom;
      hi = $urandom;
      if (wr) wq.push_back(wr_word_s'{a, (nb == NB_8) ? {hi, dd} : {32'h0, dd}, nb});
      else raq.push_back(a);
      m.beat(wr, ds, dd, nb == NB_8, hi, r, rr);
      chk(r, 2'h1);
      if (!wr) chk(rr, rd_data[31:0]);
    end
    m.stop();
  endtask

  // Single beat cycle returning the answer
  task automatic one(input logic [5:0] amc, input logic [31:0] a, input logic lw,
                     input logic ik, input logic [1:0] ds);
    m.start(amc, a, lw, ik);
    m.beat(1'b0, ds, 32'h0, 1'b0, 32'h0, rsp, rd);
    m.stop();
  endtask

  // Hang guard
  initial begin
    #900000;
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial begin
    void'($urandom(41));
    repeat (5) @(negedge mclk_i);
    rst_b = 1'b1;
    watch = 32'h0000_0110;
    // Fill the buffer until the ninth beat is held back
    fork
      blk(AM_B, 32'h100, NB_4, 1'b1, 9);
      begin
        repeat (85) @(negedge mclk_i);
        chk(dtack, 1'b0);
        chk(wr_valid, 1'b1);
        // Frozen clock enable: no pop and no acknowledge
        ce = 1'b0;
        rdy_mode = 2'h2;
        repeat (3) @(negedge mclk_i);
        chk({dtack, wr_valid}, 2'h1);
        ce = 1'b1;
        rdy_mode = 2'h1;
      end
    join
    chk(lm_cnt, 2);
    blk(AM_A, 32'h200, NB_2, 1'b0, 3);
    blk(AM_M, 32'h400, NB_8, 1'b1, 4);
    blk(AM_B, 32'h300, NB_1, 1'b1, 4);
    blk(AM_B, 32'h500, NB_4, 1'b0, 2);
    one(AM_B, 32'h600, 1'b0, 1'b1, 2'h2);
    chk(rsp, 2'h2);
    one(AM_S, 32'h602, 1'b0, 1'b1, 2'h0);
    chk(rsp, 2'h2);
    one(AM_B, 32'h0100_0000, 1'b0, 1'b1, 2'h0);
    chk(rsp, 2'h0);
    one(AM_S, 32'h604, 1'b0, 1'b0, 2'h0);
    chk(rsp, 2'h0);
    // Read-modify-write with the local side locked out
    m.start(AM_S, 32'h700, 1'b0, 1'b1);
    raq.push_back(32'h700);
    m.beat(1'b0, 2'h0, 32'h0, 1'b0, 32'h0, rsp, rd);
    chk({rsp, rd}, {2'h1, rd_data[31:0]});
    @(negedge mclk_i);
    local_req = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(local_grant, 1'b0);
    d = $urandom;
    wq.push_back(wr_word_s'{32'h700, {32'h0, d}, NB_4});
    m.beat(1'b1, 2'h0, d, 1'b0, 32'h0, rsp, rd);
    chk(rsp, 2'h1);
    m.stop();
    repeat (3) @(negedge mclk_i);
    chk(local_grant, 1'b1);
    rdy_mode = 2'h2;
    repeat (20) @(negedge mclk_i);
    chk(wq.size() + raq.size(), 0);
    chk(wr_valid, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
